// ---- core/cnm_fifo.sv ----
// parameterised valid/ready fifo for mixer output words
`timescale 1ns/10ps
`default_nettype none
module cnm_fifo #(
	parameter int WIDTH = 30,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	property p_no_overflow;
		@(posedge ref_clk) disable iff (rst)
		(count_reg == (AW+1)'(DEPTH)) && !pop |=> count_reg == (AW+1)'(DEPTH);
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("fifo count moved while full");
endmodule : cnm_fifo
`default_nettype wire

// ---- core/cnm_nco_mixer.sv ----
// carrier oscillator, quadrature mixer and serial offset loaders
`timescale 1ns/10ps
`default_nettype none
module cnm_nco_mixer
	import cnm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire cnm_cw_t cw,
	input wire logic input_sample_enable_n,
	input wire logic signed [CNM_SAMPLE_WIDTH-1:0] sample_in,
	output logic sample_ready,
	input wire logic carrier_offset_serial_data,
	input wire logic carrier_offset_word_sync,
	input wire logic resampler_offset_serial_data,
	input wire logic resampler_offset_word_sync,
	input wire logic back_end_processing_enable,
	output logic [31:0] resampler_offset_word,
	input wire logic front_end_sync_input,
	output logic iq_valid,
	input wire logic iq_ready,
	output cnm_iq_t iq_data
);
	// parabolic sine over a half turn, full 18-bit address in, 18-bit amplitude out
	function automatic logic signed [CNM_AMP_WIDTH-1:0] sine_of(input logic [17:0] addr);
		logic [16:0] u;
		logic [33:0] prod;
		logic [16:0] mag;
		u = addr[16:0];
		prod = 34'(u) * (34'h2_0000 - 34'(u));
		mag = (prod[33:15] > 19'(CNM_AMP_MAX)) ? CNM_AMP_MAX : prod[31:15];
		sine_of = addr[17] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
	endfunction : sine_of

	// symmetric rounding of a product to 15 bits, saturating the one overflow case
	function automatic logic signed [CNM_OUT_WIDTH-1:0] round15(
		input logic signed [CNM_PROD_WIDTH-1:0] p);
		logic signed [CNM_PROD_WIDTH-1:0] r;
		r = p + (p[CNM_PROD_WIDTH-1] ? 32'sh0000_7fff : 32'sh0000_8000);
		if (r[31:30] == 2'b01) begin
			round15 = 15'sh3fff;
		end else begin
			round15 = r[30:16];
		end
	endfunction : round15

	// serial word length from its two-bit code
	function automatic logic [5:0] word_len(input logic [1:0] code);
		word_len = 6'((code + 3'd1) * CNM_BITS_PER_CODE);
	endfunction : word_len

	logic [31:0] general_reg;
	logic [31:0] level_cfg_reg;
	logic [31:0] resampler_cfg_reg;
	logic [31:0] center_hold_reg;
	logic [31:0] center_act_reg;
	logic [9:0] phase_hold_reg;
	logic [9:0] phase_act_reg;
	logic [31:0] acc_reg;
	logic [31:0] cof_word_reg;

	// two-flop synchronisers for pins
	logic [1:0] eni_n_sync_reg;
	logic [CNM_SAMPLE_WIDTH-1:0] sample_meta_reg;
	logic signed [CNM_SAMPLE_WIDTH-1:0] sample_sync_reg;
	logic [1:0] fe_sync_reg;
	logic fe_sync_last_reg;
	logic [1:0] ser_data_meta_reg;
	logic [1:0] ser_data_reg;
	logic [1:0] ser_sync_meta_reg;
	logic [1:0] ser_sync_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			eni_n_sync_reg <= 2'b11;
			sample_meta_reg <= '0;
			sample_sync_reg <= '0;
			fe_sync_reg <= 2'b00;
			fe_sync_last_reg <= 1'b0;
			ser_data_meta_reg <= 2'b00;
			ser_data_reg <= 2'b00;
			ser_sync_meta_reg <= 2'b00;
			ser_sync_reg <= 2'b00;
		end else begin
			eni_n_sync_reg <= {eni_n_sync_reg[0], input_sample_enable_n};
			sample_meta_reg <= sample_in;
			sample_sync_reg <= sample_meta_reg;
			fe_sync_reg <= {fe_sync_reg[0], front_end_sync_input};
			fe_sync_last_reg <= fe_sync_reg[1];
			ser_data_meta_reg <= {resampler_offset_serial_data, carrier_offset_serial_data};
			ser_data_reg <= ser_data_meta_reg;
			ser_sync_meta_reg <= {resampler_offset_word_sync, carrier_offset_word_sync};
			ser_sync_reg <= ser_sync_meta_reg;
		end
	end

	logic cw_wr_general;
	logic cw_wr_center;
	logic cw_wr_phase;
	logic freq_xfer;
	logic phase_xfer;
	logic sync_rise;
	logic sync_xfer;
	logic clear_feedback;
	logic advance;
	logic push_ready;
	logic [31:0] incr;
	logic [31:0] phase_word;
	logic [17:0] lut_addr;
	logic signed [CNM_AMP_WIDTH-1:0] sin_val;
	logic signed [CNM_AMP_WIDTH-1:0] cos_val;
	cnm_iq_t mix;

	assign cw_wr_general = cw.wr && (cw.addr == CNM_CW_GENERAL);
	assign cw_wr_center = cw.wr && (cw.addr == CNM_CW_CARRIER_CENTER_FREQUENCY);
	assign cw_wr_phase = cw.wr && (cw.addr == CNM_CW_CARRIER_PHASE_OFFSET);
	assign sync_rise = fe_sync_reg[1] && !fe_sync_last_reg;
	assign sync_xfer = sync_rise && level_cfg_reg[CNM_LVL_SYNC_XFER_BIT];
	assign freq_xfer = (cw.wr && (cw.addr == CNM_CW_FREQ_TRANSFER)) || sync_xfer;
	assign phase_xfer = (cw.wr && (cw.addr == CNM_CW_PHASE_TRANSFER)) || sync_xfer;
	assign clear_feedback = (freq_xfer || phase_xfer) && general_reg[CNM_GEN_ACC_CLEAR_BIT];
	// a stalled fifo holds the oscillator so a refused sample takes no phase step
	assign advance = !eni_n_sync_reg[1] && push_ready;
	assign sample_ready = push_ready;
	assign incr = center_act_reg + (general_reg[CNM_GEN_OFS_ZERO_BIT] ? '0 : cof_word_reg);
	// offset lands on the top ten bits and wraps a full turn
	assign phase_word = {acc_reg[31:22] + phase_act_reg, acc_reg[21:0]};
	assign lut_addr = phase_word[31:14];
	assign sin_val = sine_of(lut_addr);
	assign cos_val = sine_of(lut_addr + CNM_QUARTER_TURN);
	assign mix.i = round15(32'(sample_sync_reg) * 32'(cos_val));
	assign mix.q = round15(32'(sample_sync_reg) * 32'(sin_val));

	// configuration words
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			general_reg <= CNM_GENERAL_RST;
			level_cfg_reg <= CNM_LEVEL_CFG_RST;
			resampler_cfg_reg <= CNM_RESAMPLER_CFG_RST;
		end else if (cw.wr) begin
			if (cw.addr == CNM_CW_GENERAL) begin
				general_reg <= cw.data;
			end else if (cw.addr == CNM_CW_LEVEL_CFG) begin
				level_cfg_reg <= cw.data;
			end else if (cw.addr == CNM_CW_RESAMPLER_CFG) begin
				resampler_cfg_reg <= cw.data;
			end
		end
	end

	// holding copies take processor writes
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			center_hold_reg <= CNM_FREQ_RST;
			phase_hold_reg <= CNM_PHASE_RST;
		end else begin
			if (cw_wr_center) begin
				center_hold_reg <= cw.data;
			end
			if (cw_wr_phase) begin
				phase_hold_reg <= cw.data[CNM_PO_WIDTH-1:0];
			end
		end
	end

	// active copies change only on a transfer
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			center_act_reg <= CNM_FREQ_RST;
			phase_act_reg <= CNM_PHASE_RST;
		end else begin
			if (freq_xfer) begin
				center_act_reg <= center_hold_reg;
			end
			if (phase_xfer) begin
				phase_act_reg <= phase_hold_reg;
			end
		end
	end

	// phase accumulator; the sum is plain modulo arithmetic, so signed words need no extra care
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			acc_reg <= CNM_FREQ_RST;
		end else begin
			acc_reg <= (clear_feedback ? '0 : acc_reg) + (advance ? incr : '0);
		end
	end

	// serial loaders: channel 0 carrier offset, channel 1 resampler offset
	logic [5:0] ser_cnt_reg [2];
	logic [5:0] ser_len_reg [2];
	logic [31:0] ser_shift_reg [2];
	logic [31:0] ser_word [2];
	logic [1:0] ser_step;
	logic [5:0] ser_len_cfg [2];

	assign ser_step = {back_end_processing_enable, 1'b1};
	assign ser_len_cfg[0] = word_len(general_reg[CNM_GEN_COF_LEN_LSB +: 2]);
	assign ser_len_cfg[1] = word_len(resampler_cfg_reg[CNM_RS_SOF_LEN_LSB +: 2]);

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			// msb first: earlier bits end up higher, then left-justify the short word
			ser_word[c] = {ser_shift_reg[c][30:0], ser_data_reg[c]} << (6'd32 - ser_len_reg[c]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int c = 0; c < 2; c++) begin
				ser_cnt_reg[c] <= '0;
				ser_len_reg[c] <= '0;
				ser_shift_reg[c] <= '0;
			end
			cof_word_reg <= CNM_FREQ_RST;
			resampler_offset_word <= CNM_FREQ_RST;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (ser_step[c]) begin
					if (ser_sync_reg[c]) begin
						ser_cnt_reg[c] <= ser_len_cfg[c];
						ser_len_reg[c] <= ser_len_cfg[c];
					end else if (ser_cnt_reg[c] != '0) begin
						ser_shift_reg[c] <= {ser_shift_reg[c][30:0], ser_data_reg[c]};
						ser_cnt_reg[c] <= ser_cnt_reg[c] - 6'd1;
						if (ser_cnt_reg[c] == 6'd1) begin
							if (c == 0) begin
								cof_word_reg <= ser_word[c];
							end else begin
								resampler_offset_word <= ser_word[c];
							end
						end
					end
				end
			end
		end
	end

	cnm_fifo #(
		.WIDTH($bits(cnm_iq_t)),
		.DEPTH(CNM_FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(!eni_n_sync_reg[1]),
		.in_ready(push_ready),
		.in_data(mix),
		.out_valid(iq_valid),
		.out_ready(iq_ready),
		.out_data(iq_data)
	);

	property p_acc_step;
		@(posedge ref_clk) disable iff (rst)
		advance && !clear_feedback |=> acc_reg == $past(acc_reg) + $past(incr);
	endproperty
	a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");

	property p_acc_hold;
		@(posedge ref_clk) disable iff (rst)
		!advance && !clear_feedback |=> $stable(acc_reg);
	endproperty
	a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved without enable");

	property p_ofs_zero;
		@(posedge ref_clk) disable iff (rst)
		general_reg[CNM_GEN_OFS_ZERO_BIT] && advance && !clear_feedback
		|=> acc_reg == $past(acc_reg) + $past(center_act_reg);
	endproperty
	a_ofs_zero: assert property (p_ofs_zero) else $error("offset term not zeroed");

	property p_freq_xfer;
		@(posedge ref_clk) disable iff (rst)
		cw.wr && cw.addr == CNM_CW_FREQ_TRANSFER |=> center_act_reg == $past(center_hold_reg);
	endproperty
	a_freq_xfer: assert property (p_freq_xfer) else $error("centre transfer missed");

	property p_active_hold;
		@(posedge ref_clk) disable iff (rst)
		!freq_xfer && !phase_xfer |=> $stable(center_act_reg) && $stable(phase_act_reg);
	endproperty
	a_active_hold: assert property (p_active_hold) else $error("active copy changed");

	property p_sync_xfer;
		@(posedge ref_clk) disable iff (rst)
		level_cfg_reg[CNM_LVL_SYNC_XFER_BIT] && fe_sync_reg[1] && !fe_sync_last_reg
		|=> center_act_reg == $past(center_hold_reg) && phase_act_reg == $past(phase_hold_reg);
	endproperty
	a_sync_xfer: assert property (p_sync_xfer) else $error("sync transfer missed");

	property p_acc_clear;
		@(posedge ref_clk) disable iff (rst)
		clear_feedback && !advance |=> acc_reg == '0;
	endproperty
	a_acc_clear: assert property (p_acc_clear) else $error("feedback not cleared");

	property p_cof_byte;
		@(posedge ref_clk) disable iff (rst)
		ser_sync_reg[0] && general_reg[CNM_GEN_COF_LEN_LSB +: 2] == 2'b00
		##1 !ser_sync_reg[0] [*8] |=> cof_word_reg[23:0] == '0;
	endproperty
	a_cof_byte: assert property (p_cof_byte) else $error("short word not left-justified");

	property p_phase_wrap;
		@(posedge ref_clk) disable iff (rst)
		32'(phase_word - acc_reg) == {phase_act_reg, 22'h00_0000};
	endproperty
	a_phase_wrap: assert property (p_phase_wrap) else $error("phase offset not applied");
endmodule : cnm_nco_mixer
`default_nettype wire

// ---- core/cnm_pkg.sv ----
// package of constants and types for the carrier oscillator and mixer
`default_nettype none
package cnm_pkg;
	// control word addresses, as indices on the control word port
	localparam logic [7:0] CNM_CW_GENERAL = 8'h00;
	localparam logic [7:0] CNM_CW_LEVEL_CFG = 8'h01;
	localparam logic [7:0] CNM_CW_CARRIER_CENTER_FREQUENCY = 8'h03;
	localparam logic [7:0] CNM_CW_CARRIER_PHASE_OFFSET = 8'h04;
	localparam logic [7:0] CNM_CW_FREQ_TRANSFER = 8'h05;
	localparam logic [7:0] CNM_CW_PHASE_TRANSFER = 8'h06;
	localparam logic [7:0] CNM_CW_RESAMPLER_CFG = 8'h0b;
	// field positions and widths
	localparam int CNM_GEN_ACC_CLEAR_BIT = 0;
	localparam int CNM_GEN_OFS_ZERO_BIT = 1;
	localparam int CNM_GEN_COF_LEN_LSB = 4;
	localparam int CNM_LVL_SYNC_XFER_BIT = 20;
	localparam int CNM_RS_SOF_LEN_LSB = 3;
	localparam int CNM_PO_WIDTH = 10;
	localparam int CNM_ACC_WIDTH = 32;
	localparam int CNM_LUT_ADDR_WIDTH = 18;
	localparam int CNM_AMP_WIDTH = 18;
	localparam int CNM_SAMPLE_WIDTH = 14;
	localparam int CNM_OUT_WIDTH = 15;
	localparam int CNM_PROD_WIDTH = 32;
	localparam int CNM_OUT_LSB = 16;
	localparam int CNM_FIFO_DEPTH = 16;
	// reset values, serial length step, quarter turn and amplitude limit
	localparam logic [31:0] CNM_GENERAL_RST = 32'h0000_0000;
	localparam logic [31:0] CNM_LEVEL_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] CNM_RESAMPLER_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] CNM_FREQ_RST = 32'h0000_0000;
	localparam logic [9:0] CNM_PHASE_RST = 10'h000;
	localparam logic [5:0] CNM_BITS_PER_CODE = 6'h08;
	localparam logic [17:0] CNM_QUARTER_TURN = 18'h1_0000;
	localparam logic [16:0] CNM_AMP_MAX = 17'h1_ffff;

	typedef struct packed {
		logic signed [CNM_OUT_WIDTH-1:0] i;
		logic signed [CNM_OUT_WIDTH-1:0] q;
	} cnm_iq_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
		logic wr;
	} cnm_cw_t;
endpackage : cnm_pkg
`default_nettype wire

// ---- sim/cnm_nco_mixer_tb.sv ----
// self-checking bench for the carrier oscillator and mixer
`timescale 1ns/10ps
`default_nettype none
module cnm_nco_mixer_tb
	import cnm_pkg::*;
;
	localparam int PK = 131071;
	logic ref_clk, rst, en_n, iq_ready, sync_in, stall, be_en;
	logic signed [13:0] smp;
	cnm_cw_t cw;
	logic sample_ready, iq_valid;
	cnm_iq_t iq_data;
	logic [31:0] rs_word;
	logic car_d, car_s, rsm_d, rsm_s;
	int num_errors, cmp_count, cyc, seed;
	logic [31:0] m_acc, m_center, m_cof, w;
	logic [9:0] m_po;
	logic m_zero;
	logic [14:0] d1, d2;
	cnm_iq_t exp_q[$];

	cnm_src_model src (.ref_clk(ref_clk), .car_data(car_d), .car_sync(car_s),
		.rsm_data(rsm_d), .rsm_sync(rsm_s));

	cnm_nco_mixer uut (.ref_clk(ref_clk), .rst(rst), .cw(cw), .input_sample_enable_n(en_n),
		.sample_in(smp), .sample_ready(sample_ready), .carrier_offset_serial_data(car_d),
		.carrier_offset_word_sync(car_s), .resampler_offset_serial_data(rsm_d),
		.resampler_offset_word_sync(rsm_s), .back_end_processing_enable(be_en),
		.resampler_offset_word(rs_word), .front_end_sync_input(sync_in),
		.iq_valid(iq_valid), .iq_ready(iq_ready), .iq_data(iq_data));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic close_out();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	task automatic fail(input string msg);
		$display("CHECK FAILED %0t %s", $time, msg);
		num_errors++;
	endtask : fail

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) fail(msg);
	endtask : chk_word

	task automatic chk_iq(input cnm_iq_t got, input cnm_iq_t exp);
		cmp_count++;
		if (got !== exp) fail("i/q word differs");
	endtask : chk_iq

	// symmetric rounding of sample times amplitude, bits 30:16 kept
	function automatic logic [14:0] rnd(input logic signed [13:0] s, input int a);
		longint m;
		m = longint'(s) * a;
		m = (m < 0) ? -m : m;
		m = (m + 32768) >>> 16;
		// the one positive overflow saturates instead of wrapping
		if (m > 16383 && longint'(s) * a > 0) m = 16383;
		return (longint'(s) * a < 0) ? 15'(-m) : 15'(m);
	endfunction : rnd

	// phase held on quarter turns, so table values are peak, zero or minus peak
	function automatic cnm_iq_t mix(input logic signed [13:0] s, input logic [1:0] q);
		int c[4] = '{PK, 0, -PK, 0};
		mix.i = rnd(s, c[q]);
		mix.q = rnd(s, c[2'(q - 2'd1)]);
	endfunction : mix

	// reference oscillator: follows the two-flop sample path
	always @(posedge ref_clk) begin
		d1 <= {~en_n, smp};
		d2 <= d1;
		if (d2[14] === 1'b1 && sample_ready === 1'b1 && rst === 1'b0) begin
			exp_q.push_back(mix(d2[13:0], 2'(m_acc[31:30] + m_po[9:8])));
			m_acc <= m_acc + m_center + (m_zero ? 32'h0 : m_cof);
		end
	end

	// back-end enable at half the sample clock rate
	always @(posedge ref_clk) be_en <= ~be_en;

	always @(posedge ref_clk) begin
		iq_ready <= stall ? 1'b0 : 1'($random(seed));
		cyc++;
		if (cyc > 20000) begin
			num_errors++;
			close_out();
		end else if (iq_valid === 1'b1 && iq_ready === 1'b1) begin
			if (exp_q.size() == 0) fail("output with no sample pending");
			else chk_iq(iq_data, exp_q.pop_front());
		end
	end

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		cw <= '{a, d, 1'b1};
		@(posedge ref_clk);
		cw.wr <= 1'b0;
	endtask : wr

	task automatic run(input int n, input logic full);
		repeat (n) begin
			@(posedge ref_clk);
			en_n <= full ? 1'b0 : 1'($random(seed));
			smp <= 14'($random(seed));
		end
		@(posedge ref_clk);
		en_n <= 1'b1;
		idle(5);
	endtask : run

	task automatic pulse();
		@(posedge ref_clk);
		sync_in <= 1'b1;
		idle(3);
		sync_in <= 1'b0;
		idle(6);
	endtask : pulse

	initial begin
		seed = 32'h9518;
		{en_n, rst, be_en} = 3'b111;
		{sync_in, stall, iq_ready, m_zero} = 4'h0;
		{smp, d1, d2} = '0;
		cw = '0;
		{num_errors, cmp_count, cyc} = '0;
		{m_acc, m_center, m_cof, m_po} = '0;
		idle(8);
		rst <= 1'b0;
		wr(CNM_CW_GENERAL, 32'h1);
		wr(CNM_CW_CARRIER_CENTER_FREQUENCY, 32'h4000_0000);
		run(8, 1'b0);
		wr(CNM_CW_FREQ_TRANSFER, 32'h0);
		{m_center, m_acc} = {32'h4000_0000, 32'h0};
		run(12, 1'b0);
		wr(CNM_CW_CARRIER_PHASE_OFFSET, 32'hffff_fd00);
		wr(8'h07, 32'hffff_ffff);
		run(6, 1'b0);
		wr(CNM_CW_PHASE_TRANSFER, 32'h0);
		{m_po, m_acc} = {10'h100, 32'h0};
		run(10, 1'b0);
		wr(CNM_CW_CARRIER_CENTER_FREQUENCY, 32'hc000_0000);
		pulse();
		run(6, 1'b0);
		wr(CNM_CW_LEVEL_CFG, 32'h0010_0000);
		pulse();
		{m_center, m_acc} = {32'hc000_0000, 32'h0};
		run(10, 1'b0);
		wr(CNM_CW_CARRIER_CENTER_FREQUENCY, 32'h0);
		wr(CNM_CW_FREQ_TRANSFER, 32'h0);
		{m_center, m_acc} = '0;
		src.send(1'b0, 6'd8, 32'h40a5_5a5a);
		idle(4);
		m_cof = 32'h4000_0000;
		run(10, 1'b0);
		wr(CNM_CW_GENERAL, 32'h13);
		m_zero = 1'b1;
		src.send(1'b0, 6'd16, 32'h8000_c3c3);
		idle(4);
		m_cof = 32'h8000_0000;
		run(8, 1'b0);
		wr(CNM_CW_GENERAL, 32'h11);
		m_zero = 1'b0;
		run(8, 1'b0);
		stall = 1'b1;
		run(24, 1'b1);
		#1;
		chk_word(32'(sample_ready), 32'h0, "fifo full not refused");
		chk_word(32'(exp_q.size()), 32'd16, "fifo depth");
		stall = 1'b0;
		for (int k = 0; k < 300 && exp_q.size() > 0; k++) @(posedge ref_clk);
		chk_word(32'(exp_q.size()), 32'h0, "fifo not drained");
		// transfer with the clear bit off keeps the phase running
		wr(CNM_CW_GENERAL, 32'h10);
		wr(CNM_CW_FREQ_TRANSFER, 32'h0);
		run(8, 1'b0);
		for (int c = 3; c >= 0; c--) begin
			wr(CNM_CW_RESAMPLER_CFG, 32'(c) << 3);
			w = $random(seed);
			src.send(1'b1, 6'(8 * (c + 1)), w);
			idle(4);
			#1;
			chk_word(rs_word, w & (32'hffff_ffff << (32 - 8 * (c + 1))), "resampler word");
		end
		close_out();
	end
endmodule : cnm_nco_mixer_tb
`default_nettype wire

// ---- sim/cnm_src_model.sv ----
// serial offset word source standing in for the external tracking loop
`timescale 1ns/10ps
`default_nettype none
module cnm_src_model (
	input wire logic ref_clk,
	output logic car_data,
	output logic car_sync,
	output logic rsm_data,
	output logic rsm_sync
);
	logic busy;

	initial begin
		car_data = 1'b0;
		car_sync = 1'b0;
		rsm_data = 1'b0;
		rsm_sync = 1'b0;
		busy = 1'b0;
	end

	// idle data lines toggle so a stale bit never passes for a live one
	always @(posedge ref_clk) begin
		if (!busy) begin
			car_data <= ~car_data;
			rsm_data <= ~rsm_data;
		end
	end

	// word is left-justified; only the top len bits go out
	// resampler pins hold each value two cycles, one period of the half-rate back-end enable
	task automatic send(input logic sel, input logic [5:0] len, input logic [31:0] word);
		int per;
		per = sel ? 2 : 1;
		@(posedge ref_clk);
		if (sel) begin
			rsm_sync <= 1'b1;
		end else begin
			car_sync <= 1'b1;
		end
		busy <= 1'b1;
		for (int k = 0; k < len; k++) begin
			repeat (per) @(posedge ref_clk);
			car_sync <= 1'b0;
			rsm_sync <= 1'b0;
			if (sel) begin
				rsm_data <= word[31-k];
			end else begin
				car_data <= word[31-k];
			end
		end
		repeat (per) @(posedge ref_clk);
		busy <= 1'b0;
	endtask : send
endmodule : cnm_src_model
`default_nettype wire
